// ### scd_decoder.sv
// Overview of operation
// - Reset opcode restores defaults within 18 master periods.
// - Start begins conversions; while already running it only cancels a pending stop.
// - Stop finishes current conversion, then halts.
// - System opcodes accepted outside continuous mode, any clock rate.
// - Continuous mode loads result at each data-ready.
// - Continuous mode acts only on stop-continuous opcode.
// - Idle continuous-mode output mirrors data-ready waveform.
// - Stop-continuous ends continuous mode; host waits 4.
// - Single read result survives overlapping next data-ready.
// - Each byte completing outside reset execution executes within 4 master periods.
// - Register read: 001+address, then 000+count-1.
// - First register MSB appears on rising edge 17.
// - Register write stores bytes at successive addresses.
// - Opcodes 06,08,0a,10,11,12 decode as listed; 02 and 04 have no effect.
// - Opcodes decode on the falling edge ending the byte.
// - Register read ignored during continuous mode.
`timescale 1ns/1ps
`default_nettype none
module scd_decoder
    import scd_pkg::*;
#(
    parameter int DATA_W   = SCD_DATA_W,
    parameter int MCLK_DIV = SCD_MCLK_DIV
) (
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic              sclk,
    input  wire logic              cs_n,
    input  wire logic              din,
    input  wire logic              start_pin,
    input  wire logic              conv_done,
    input  wire logic [DATA_W-1:0] conv_data,
    output var  logic              dout,
    output var  logic              dout_oe,
    output var  logic              data_ready_n,
    output var  logic              conv_run,
    output var  logic              filter_restart
);

    localparam int RST_MAX = SCD_RESET_PERIODS * MCLK_DIV + 1; // Longest reset execution in system cycles.

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, bit order {start_pin, din, cs_n, sclk}.
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic       sclk_prev_q;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_s;
    logic       din_s;
    logic       start_s;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q     <= 4'h2;
            sync2_q     <= 4'h2;
            sclk_prev_q <= 1'b0;
        end else begin
            sync1_q     <= {start_pin, din, cs_n, sclk};
            sync2_q     <= sync1_q;
            sclk_prev_q <= sync2_q[0];
        end
    end

    // Edge finding on the synchronised serial clock.
    assign sclk_rise = sync2_q[0] & ~sclk_prev_q & ~sync2_q[1];
    assign sclk_fall = ~sync2_q[0] & sclk_prev_q & ~sync2_q[1];
    assign cs_s      = ~sync2_q[1];
    assign din_s     = sync2_q[2];
    assign start_s   = sync2_q[3];

    ////////////////////////////////////////////////////////////////////////////
    // Master clock period enable from a divider.
    logic [7:0] div_q;
    logic [7:0] div_d;
    logic       tick_q;
    logic       tick_d;

    always_comb begin
        tick_d = (div_q == 8'(MCLK_DIV - 1));
        div_d  = tick_d ? 8'h00 : div_q + 8'h01;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div_q  <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command state.
    scd_state_t        st_q, st_d;
    logic [3:0]        bit_q, bit_d;
    logic [6:0]        shin_q, shin_d;
    logic [4:0]        addr_q, addr_d;
    logic [4:0]        cnt_q, cnt_d;
    logic [2:0]        rbit_q, rbit_d;
    logic              wr_q, wr_d;
    logic              cont_q, cont_d;
    logic              run_q, run_d;
    logic              stop_pend_q, stop_pend_d;
    logic [4:0]        rst_cnt_q, rst_cnt_d;
    logic [2:0]        upd_q, upd_d;
    logic              data_ready_n_q, data_ready_n_d;
    logic              retr_q, retr_d;
    logic [DATA_W-1:0] dsr_q, dsr_d;
    logic [DATA_W-1:0] result_q, result_d;
    logic              dout_q, dout_d;
    logic              oe_q;
    logic              restart_q, restart_d;
    logic              conv_run_q;
    logic [7:0]        byte_in;
    logic              byte_done;
    logic              do_reset, do_start, do_stop, do_stop_cont, do_read_once;
    logic              mem_we;
    logic              mem_clear;
    logic [7:0]        mem_rdata;

    assign byte_in   = {shin_q, din_s};
    assign byte_done = sclk_fall && bit_q == 4'(SCD_BYTE_BITS - 1) && rst_cnt_q == 5'h00;

    // Opcode decode; only stop-continuous is honoured in continuous mode.
    always_comb begin
        logic opc;
        opc          = byte_done && st_q == SCD_ST_OPCODE;
        do_stop_cont = opc && byte_in == SCD_OP_STOP_CONT;
        do_reset     = opc && !cont_q && byte_in == SCD_OP_RESET;
        do_start     = opc && !cont_q && byte_in == SCD_OP_START;
        do_stop      = opc && !cont_q && byte_in == SCD_OP_STOP;
        do_read_once = opc && !cont_q && byte_in == SCD_OP_READ_ONCE;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic; every byte completing outside reset execution is executed in the cycle it completes.
    always_comb begin
        st_d        = st_q;
        bit_d       = bit_q;
        shin_d      = shin_q;
        addr_d      = addr_q;
        cnt_d       = cnt_q;
        rbit_d      = rbit_q;
        wr_d        = wr_q;
        cont_d      = cont_q;
        run_d       = run_q;
        stop_pend_d = stop_pend_q;
        rst_cnt_d   = rst_cnt_q;
        upd_d       = upd_q;
        data_ready_n_d      = data_ready_n_q;
        retr_d      = retr_q;
        dsr_d       = dsr_q;
        result_d    = result_q;
        dout_d      = dout_q;
        restart_d   = 1'b0;
        mem_we      = 1'b0;
        mem_clear   = 1'b0;
        // Bit assembly on falling edges; chip select high aborts a command.
        if (!cs_s) begin
            bit_d = 4'h0;
            st_d  = SCD_ST_OPCODE;
        end else if (sclk_fall) begin
            bit_d  = (bit_q == 4'(SCD_BYTE_BITS - 1)) ? 4'h0 : bit_q + 4'h1;
            shin_d = byte_in[6:0];
        end
        if (rst_cnt_q != 5'h00 && tick_q) begin
            rst_cnt_d = rst_cnt_q - 5'h01;
        end
        // Byte execution, finished well inside the decode gap.
        if (byte_done) begin
            unique case (st_q)
                SCD_ST_OPCODE: begin
                    if (do_stop_cont) begin
                        cont_d = 1'b0;
                    end else if (cont_q) begin
                        cont_d = 1'b1;
                    end else if (do_reset) begin
                        rst_cnt_d   = 5'(SCD_RESET_PERIODS);
                        mem_clear   = 1'b1;
                        restart_d   = 1'b1;
                        run_d       = 1'b0;
                        stop_pend_d = 1'b0;
                        cont_d      = 1'b1;
                    end else if (do_start) begin
                        stop_pend_d = 1'b0;
                        if (!run_q) begin
                            run_d     = 1'b1;
                            restart_d = 1'b1;
                        end
                    end else if (do_stop) begin
                        stop_pend_d = run_q;
                    end else if (byte_in == SCD_OP_READ_CONT) begin
                        cont_d = 1'b1;
                    end else if (do_read_once) begin
                        dsr_d = result_q;
                    end else if (scd_has_prefix(byte_in, SCD_PFX_REG_READ)
                                 || scd_has_prefix(byte_in, SCD_PFX_REG_WRITE)) begin
                        addr_d = byte_in[4:0];
                        wr_d   = scd_has_prefix(byte_in, SCD_PFX_REG_WRITE);
                        st_d   = SCD_ST_COUNT;
                    end
                end
                SCD_ST_COUNT: begin
                    if (scd_has_prefix(byte_in, SCD_PFX_COUNT)) begin
                        cnt_d  = byte_in[4:0];
                        rbit_d = 3'h7;
                        st_d   = wr_q ? SCD_ST_REG_WRITE : SCD_ST_REG_READ;
                    end else begin
                        st_d = SCD_ST_OPCODE;
                    end
                end
                SCD_ST_REG_WRITE: begin
                    mem_we = 1'b1;
                    addr_d = addr_q + 5'h01;
                    cnt_d  = cnt_q - 5'h01;
                    if (cnt_q == 5'h00) begin
                        st_d = SCD_ST_OPCODE;
                    end
                end
                SCD_ST_REG_READ: begin
                end
            endcase
        end
        // Data out changes on rising edges, and follows data-ready in idle continuous mode.
        if (sclk_rise) begin
            if (st_q == SCD_ST_REG_READ) begin
                dout_d = mem_rdata[rbit_q];
                rbit_d = rbit_q - 3'h1;
                if (rbit_q == 3'h0) begin
                    addr_d = addr_q + 5'h01;
                    cnt_d  = cnt_q - 5'h01;
                    if (cnt_q == 5'h00) begin
                        st_d = SCD_ST_OPCODE;
                    end
                end
            end else begin
                dout_d = dsr_q[DATA_W-1];
                dsr_d  = {dsr_q[DATA_W-2:0], 1'b0};
                retr_d = 1'b1;
            end
        end else if (cont_q && !retr_q) begin
            dout_d = data_ready_n_q;
        end
        // Data-ready: high through the update time, low once fresh data waits.
        if (sclk_fall && !data_ready_n_q && upd_q == 3'h0) begin
            data_ready_n_d = 1'b1;
        end
        if (upd_q != 3'h0 && tick_q) begin
            upd_d = upd_q - 3'h1;
            if (upd_q == 3'h1) begin
                data_ready_n_d = 1'b0;
            end
        end
        if (conv_done) begin
            result_d = conv_data;
            data_ready_n_d   = 1'b1;
            upd_d    = 3'(SCD_UPDATE_PERIODS);
            retr_d   = 1'b0;
            if (cont_q) begin
                dsr_d = conv_data;
            end
            if (stop_pend_q) begin
                run_d       = 1'b0;
                stop_pend_d = 1'b0;
            end
        end
    end

    // Command state registers.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_q        <= SCD_ST_OPCODE;
            bit_q       <= 4'h0;
            shin_q      <= 7'h00;
            addr_q      <= 5'h00;
            cnt_q       <= 5'h00;
            rbit_q      <= 3'h7;
            wr_q        <= 1'b0;
            cont_q      <= 1'b1;
            run_q       <= 1'b0;
            stop_pend_q <= 1'b0;
            rst_cnt_q   <= 5'h00;
            upd_q       <= 3'h0;
            data_ready_n_q      <= 1'b1;
            retr_q      <= 1'b0;
            dsr_q       <= '0;
            result_q    <= '0;
            dout_q      <= 1'b1;
            oe_q        <= 1'b0;
            restart_q   <= 1'b0;
            conv_run_q  <= 1'b0;
        end else begin
            st_q        <= st_d;
            bit_q       <= bit_d;
            shin_q      <= shin_d;
            addr_q      <= addr_d;
            cnt_q       <= cnt_d;
            rbit_q      <= rbit_d;
            wr_q        <= wr_d;
            cont_q      <= cont_d;
            run_q       <= run_d;
            stop_pend_q <= stop_pend_d;
            rst_cnt_q   <= rst_cnt_d;
            upd_q       <= upd_d;
            data_ready_n_q      <= data_ready_n_d;
            retr_q      <= retr_d;
            dsr_q       <= dsr_d;
            result_q    <= result_d;
            dout_q      <= dout_d;
            oe_q        <= cs_s;
            restart_q   <= restart_d;
            conv_run_q  <= run_d | start_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register storage.
    scd_regmem u_regmem (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .clear   (mem_clear),
        .we      (mem_we),
        .waddr   (addr_q),
        .wdata   (byte_in),
        .raddr   (addr_q),
        .rdata   (mem_rdata)
    );

    // Outputs straight from flip-flops.
    assign dout           = dout_q;
    assign dout_oe        = oe_q;
    assign data_ready_n   = data_ready_n_q;
    assign conv_run       = conv_run_q;
    assign filter_restart = restart_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_reset_taken;
        do_reset ##1 (rst_cnt_q == 5'(SCD_RESET_PERIODS) && restart_q);
    endsequence
    property p_reset_done;
        s_reset_taken |-> ##[1:RST_MAX] (rst_cnt_q == 5'h00);
    endproperty
    a_reset_done: assert property (p_reset_done) else $error("reset not finished in time");

    property p_start_ignored;
        do_start && run_q |=> run_q && !restart_q;
    endproperty
    a_start_ignored: assert property (p_start_ignored) else $error("start disturbed running conversions");

    property p_stop_finish;
        do_stop && run_q && !conv_done |=> run_q && stop_pend_q;
    endproperty
    a_stop_finish: assert property (p_stop_finish) else $error("stop cut the running conversion short");

    property p_stop_after_conv;
        stop_pend_q && conv_done && !byte_done |=> !run_q && !stop_pend_q;
    endproperty
    a_stop_after_conv: assert property (p_stop_after_conv) else $error("stop did not halt after conversion");

    property p_cont_load;
        cont_q && conv_done |=> dsr_q == $past(conv_data) && data_ready_n_q;
    endproperty
    a_cont_load: assert property (p_cont_load) else $error("continuous load missing");

    property p_cont_only_stop;
        cont_q && byte_done && st_q == SCD_ST_OPCODE && byte_in != SCD_OP_STOP_CONT
            |=> cont_q && st_q == SCD_ST_OPCODE && !restart_q;
    endproperty
    a_cont_only_stop: assert property (p_cont_only_stop) else $error("command acted on in continuous mode");

    property p_mirror;
        cont_q && !retr_q && !sclk_rise |=> dout_q == $past(data_ready_n_q);
    endproperty
    a_mirror: assert property (p_mirror) else $error("output does not follow data-ready");

    property p_stop_cont;
        do_stop_cont |=> !cont_q;
    endproperty
    a_stop_cont: assert property (p_stop_cont) else $error("stop-continuous ignored");

    property p_result_kept;
        !cont_q && conv_done && !sclk_rise && !do_read_once |=> $stable(dsr_q);
    endproperty
    a_result_kept: assert property (p_result_kept) else $error("pending result corrupted");

    property p_register_read_cmd_decode;
        byte_done && st_q == SCD_ST_COUNT && !wr_q && byte_in[7:5] == 3'h0
            |=> st_q == SCD_ST_REG_READ && cnt_q == $past(byte_in[4:0]) && rbit_q == 3'h7;
    endproperty
    a_register_read_cmd_decode: assert property (p_register_read_cmd_decode) else $error("register read count not taken");

    property p_first_msb;
        st_q == SCD_ST_REG_READ && sclk_rise && rbit_q == 3'h7 |=> dout_q == $past(mem_rdata[7]);
    endproperty
    a_first_msb: assert property (p_first_msb) else $error("register msb not presented");

    property p_write_step;
        byte_done && st_q == SCD_ST_REG_WRITE |-> mem_we ##1 addr_q == $past(addr_q) + 5'h01;
    endproperty
    a_write_step: assert property (p_write_step) else $error("register write did not advance");

    property p_start_code;
        do_start && !run_q |=> run_q && restart_q ##1 !restart_q;
    endproperty
    a_start_code: assert property (p_start_code) else $error("start opcode not executed");

endmodule
`default_nettype wire

// ### scd_host.sv
`timescale 1ns/1ps
`default_nettype none
module scd_host (
    input  wire logic clk_sys,
    input  wire logic dout,
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic din
);
    logic [7:0] rx;

    // The link rests with sclk low and chip select high between frames.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
        rx   = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sends one byte MSB first at a 400 ns period and samples dout on each fall.
    task automatic xfer(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            repeat (4) @(negedge clk_sys);
            sclk = 1'b1;
            din  = b[i];
            repeat (4) @(negedge clk_sys);
            rx   = {rx[6:0], dout};
            sclk = 1'b0;
        end
    endtask

    // Sends n bytes under one chip select; a byte takes far longer than the decode gap.
    task automatic frame(input logic [31:0] bytes, input int n);
        cs_n = 1'b0;
        for (int k = n - 1; k >= 0; k--) begin
            xfer(bytes[k*8 +: 8]);
        end
        repeat (4) @(negedge clk_sys);
        cs_n = 1'b1;
        din  = ~din; // The released line does not keep its last level.
        repeat (40) @(negedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ### scd_pkg.sv
`default_nettype none
package scd_pkg;

    // Single-byte opcodes.
    localparam logic [7:0] SCD_OP_WAKE      = 8'h02;
    localparam logic [7:0] SCD_OP_STANDBY   = 8'h04;
    localparam logic [7:0] SCD_OP_RESET     = 8'h06;
    localparam logic [7:0] SCD_OP_START     = 8'h08;
    localparam logic [7:0] SCD_OP_STOP      = 8'h0a;
    localparam logic [7:0] SCD_OP_READ_CONT = 8'h10;
    localparam logic [7:0] SCD_OP_STOP_CONT = 8'h11;
    localparam logic [7:0] SCD_OP_READ_ONCE = 8'h12;

    // Prefixes in bits 7:5 of the two-byte register commands.
    localparam logic [2:0] SCD_PFX_REG_READ  = 3'h1;
    localparam logic [2:0] SCD_PFX_REG_WRITE = 3'h2;
    localparam logic [2:0] SCD_PFX_COUNT     = 3'h0;

    // Field layout.
    localparam int SCD_BYTE_BITS = 8;
    localparam int SCD_ADDR_W    = 5;
    localparam int SCD_NUM_REGS  = 32;
    localparam int SCD_DATA_W    = 216;

    // Timing: system clock, master clock and gaps in master clock periods.
    localparam int SCD_SYS_CLK_NS      = 50;
    localparam int SCD_MCLK_PERIOD_NS  = 488;
    localparam int SCD_MCLK_DIV        = (SCD_MCLK_PERIOD_NS + SCD_SYS_CLK_NS - 1) / SCD_SYS_CLK_NS;
    localparam int SCD_RESET_PERIODS   = 18;
    localparam int SCD_DECODE_PERIODS  = 4;
    localparam int SCD_UPDATE_PERIODS  = 4;

    // Register reset values.
    localparam logic [4:0] SCD_ADDR_CFG1 = 5'h01;
    localparam logic [4:0] SCD_ADDR_CFG2 = 5'h02;
    localparam logic [4:0] SCD_ADDR_CFG3 = 5'h03;
    localparam logic [4:0] SCD_ADDR_GPIO = 5'h14;
    localparam logic [7:0] SCD_RST_CFG1  = 8'h06;
    localparam logic [7:0] SCD_RST_CFG2  = 8'h40;
    localparam logic [7:0] SCD_RST_CFG3  = 8'h40;
    localparam logic [7:0] SCD_RST_GPIO  = 8'h0f;

    typedef enum logic [1:0] {
        SCD_ST_OPCODE    = 2'b00,
        SCD_ST_COUNT     = 2'b01,
        SCD_ST_REG_READ  = 2'b10,
        SCD_ST_REG_WRITE = 2'b11
    } scd_state_t;

    // Reset value of one register.
    function automatic logic [7:0] scd_reg_default(input logic [4:0] addr);
        unique case (addr)
            SCD_ADDR_CFG1: scd_reg_default = SCD_RST_CFG1;
            SCD_ADDR_CFG2: scd_reg_default = SCD_RST_CFG2;
            SCD_ADDR_CFG3: scd_reg_default = SCD_RST_CFG3;
            SCD_ADDR_GPIO: scd_reg_default = SCD_RST_GPIO;
            default:       scd_reg_default = 8'h00;
        endcase
    endfunction

    // True when the byte carries the given three-bit prefix.
    function automatic logic scd_has_prefix(input logic [7:0] b, input logic [2:0] pfx);
        scd_has_prefix = (b[7:5] == pfx);
    endfunction

endpackage
`default_nettype wire

// ### scd_regmem.sv
`timescale 1ns/1ps
`default_nettype none
module scd_regmem
    import scd_pkg::*;
#(
    parameter int ADDR_W = SCD_ADDR_W,
    parameter int DEPTH  = SCD_NUM_REGS
) (
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic              clear,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] waddr,
    input  wire logic [7:0]        wdata,
    input  wire logic [ADDR_W-1:0] raddr,
    output var  logic [7:0]        rdata
);

    logic [7:0] mem_q [DEPTH];
    logic [7:0] mem_d [DEPTH];
    logic [7:0] rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Clear restores every default, otherwise a write updates one entry.
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            if (clear) begin
                mem_d[i] = scd_reg_default(ADDR_W'(i));
            end else if (we && waddr == ADDR_W'(i)) begin
                mem_d[i] = wdata;
            end else begin
                mem_d[i] = mem_q[i];
            end
        end
    end

    // Storage and registered read port.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= scd_reg_default(ADDR_W'(i));
            end
            rdata_q <= 8'h00;
        end else begin
            mem_q   <= mem_d;
            rdata_q <= mem_q[raddr];
        end
    end

    assign rdata = rdata_q;

endmodule
`default_nettype wire

// ### serial_command_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_command_decoder_tb;
    import scd_pkg::*;
    logic                  clk_sys   = 1'b0;
    logic                  reset_n   = 1'b0;
    logic                  start_pin = 1'b0;
    logic                  conv_done = 1'b0;
    logic [SCD_DATA_W-1:0] conv_data = {27{8'h5a}};
    logic                  sclk, cs_n, din, dout, dout_oe, data_ready_n, conv_run, filter_restart;
    int                    fails       = 0;
    int                    comparisons = 0;
    int                    restarts    = 0;

    // The system clock runs at 20 MHz.
    always #25 clk_sys = ~clk_sys;

    scd_decoder #(.MCLK_DIV(2)) dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
        .din(din), .start_pin(start_pin), .conv_done(conv_done), .conv_data(conv_data), .dout(dout),
        .dout_oe(dout_oe), .data_ready_n(data_ready_n), .conv_run(conv_run), .filter_restart(filter_restart));
    scd_host host_u (.clk_sys(clk_sys), .dout(dout), .sclk(sclk), .cs_n(cs_n), .din(din));

    // Counts filter restart pulses, sampled where they are settled.
    always @(negedge clk_sys) begin
        if (filter_restart === 1'b1) begin
            restarts++;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Pulses conversion-done for one cycle with every byte of the result set to v.
    task automatic pulse(input logic [7:0] v);
        conv_data = {27{v}};
        conv_done = 1'b1;
        @(negedge clk_sys);
        conv_done = 1'b0;
    endtask

    // Reads one register back through a three-byte frame.
    task automatic read_reg(input logic [4:0] a, input logic [7:0] exp);
        host_u.frame({8'h00, SCD_PFX_REG_READ, a, 16'h0000}, 3);
        check(host_u.rx, exp);
    endtask

    // Start is ignored in continuous mode until stop-continuous arrives.
    task automatic t_cont_mode;
        host_u.frame({24'h0, SCD_OP_START}, 1);
        check({7'h0, conv_run}, 8'h00);
        host_u.frame({24'h0, SCD_OP_STOP_CONT}, 1);
        read_reg(5'h02, 8'h40);
    endtask

    // Writes two successive registers, then reads each back.
    task automatic t_regs;
        host_u.frame(32'h45_01_a5_3c, 4);
        read_reg(5'h05, 8'ha5);
        read_reg(5'h06, 8'h3c);
        host_u.frame(32'h00_41_00_33, 3);
        read_reg(5'h01, 8'h33);
    endtask

    // Start runs conversions; stop halts only after the conversion in flight.
    task automatic t_start_stop;
        host_u.frame({24'h0, SCD_OP_START}, 1);
        check({7'h0, conv_run}, 8'h01);
        host_u.frame({24'h0, SCD_OP_START}, 1);
        check({7'h0, conv_run}, 8'h01);
        check(8'(restarts), 8'h01);
        host_u.frame({24'h0, SCD_OP_STOP}, 1);
        check({7'h0, conv_run}, 8'h01);
        pulse(8'h5a);
        repeat (3) @(negedge clk_sys);
        check({7'h0, conv_run}, 8'h00);
    endtask

    // Reset opcode stops conversions and restores defaults.
    task automatic t_reset_cmd;
        host_u.frame({24'h0, SCD_OP_START}, 1);
        host_u.frame({24'h0, SCD_OP_RESET}, 1);
        check({7'h0, conv_run}, 8'h00);
        check(8'(restarts), 8'h03);
        host_u.frame({24'h0, SCD_OP_STOP_CONT}, 1);
        read_reg(5'h01, SCD_RST_CFG1);
        host_u.frame({24'h0, SCD_OP_STOP}, 1);
        start_pin = 1'b1;
        repeat (6) @(negedge clk_sys);
        check({7'h0, conv_run}, 8'h01);
        start_pin = 1'b0;
    endtask

    // Single read survives an overlapping conversion; continuous mode mirrors and streams data.
    task automatic t_readout;
        pulse(8'h5a);
        repeat (12) @(negedge clk_sys);
        check({7'h0, data_ready_n}, 8'h00);
        fork
            host_u.frame({16'h0, SCD_OP_READ_ONCE, 8'h00}, 2);
            begin
                repeat (90) @(negedge clk_sys);
                check({7'h0, dout_oe}, 8'h01);
                pulse(8'h3c);
            end
        join
        check(host_u.rx, 8'h5a);
        host_u.frame({24'h0, SCD_OP_READ_CONT}, 1);
        pulse(8'hc3);
        @(negedge clk_sys);
        check({6'h0, dout, data_ready_n}, 8'h03);
        repeat (10) @(negedge clk_sys);
        check({6'h0, dout, data_ready_n}, 8'h00);
        read_reg(5'h02, 8'hc3);
    endtask

    // Prints the verdict and ends the run.
    task automatic report_and_stop;
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Main sequence: reset for six cycles, then each scenario in turn.
    initial begin
        repeat (6) @(negedge clk_sys);
        check({5'h0, dout_oe, data_ready_n, conv_run}, 8'h02);
        reset_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        t_cont_mode();
        t_regs();
        t_start_stop();
        t_reset_cmd();
        t_readout();
        report_and_stop();
    end

    // Cuts a hang short.
    initial begin
        #2ms;
        fails++;
        report_and_stop();
    end
endmodule
`default_nettype wire
